// ==== hdl/cgs_pkg.sv ====
// Types and constants shared by the complex gate and storage cell block
package cgs_pkg;

  // Set/reset latch states, Gray coded along zero -> one -> forced
  typedef enum logic [1:0] {
    CGS_RS_ZERO = 2'h0,
    CGS_RS_ONE = 2'h1,
    CGS_RS_FORCED = 2'h3
  } cgs_rs_e;

  // Cell inputs, all sampled on clk
  typedef struct packed {
    logic [1:0] ao_pair;
    logic ao_ovr;
    logic [1:0] on_pair;
    logic on_ovr;
    logic [1:0] x_in;
    logic rs_set;
    logic rs_reset;
    logic timing_input;
    logic cl_data;
    logic cl_reset;
    logic ff_data;
    logic ff_set;
    logic ff_reset;
  } cgs_in_s;

  // Cell outputs, each from a flip-flop
  typedef struct packed {
    logic and_nor;
    logic or_nand;
    logic diff;
    logic match;
    logic rs_q;
    logic rs_qn;
    logic cl_q;
    logic cl_qn;
    logic ff_q;
    logic ff_qn;
  } cgs_out_s;

  // Whole state of the block
  typedef struct packed {
    cgs_rs_e rs;
    logic cl_store;
    logic tim_prev;
    logic ff_master;
    cgs_out_s outs;
  } cgs_state_s;

  // Outputs after reset: gates as for all-zero inputs, storage cells cleared
  localparam cgs_out_s CGS_OUT_RST = '{
    and_nor: 1'b1, or_nand: 1'b1, diff: 1'b0, match: 1'b1,
    rs_q: 1'b0, rs_qn: 1'b1, cl_q: 1'b0, cl_qn: 1'b1, ff_q: 1'b0, ff_qn: 1'b1
  };

  localparam cgs_state_s CGS_STATE_RST = '{
    rs: CGS_RS_ZERO, cl_store: 1'b0, tim_prev: 1'b0, ff_master: 1'b0,
    outs: CGS_OUT_RST
  };

  localparam logic [1:0] CGS_SYNC_RST = 2'h0;
  localparam logic [1:0] CGS_SYNC_SET = 2'h3;

  // Set/reset latch input codes, {set, reset}
  localparam logic [1:0] CGS_RS_IN_HOLD = 2'h0;
  localparam logic [1:0] CGS_RS_IN_RESET = 2'h1;
  localparam logic [1:0] CGS_RS_IN_SET = 2'h2;
  localparam logic [1:0] CGS_RS_IN_BOTH = 2'h3;

  // True and complement both low
  localparam logic [1:0] CGS_PAIR_LOW = 2'h0;

endpackage : cgs_pkg

// ==== hdl/cgs_cells.sv ====
// Complex gates, set/reset latch, clocked latch and master-slave flip-flop
// Notes on behaviour
// - AND/NOR output low if both paired inputs high or override high, else high.
// - OR/NAND output high if override low or both paired inputs low, else low.
// - Exclusive-OR outputs one exactly when its two inputs differ.
// - Exclusive-NOR outputs one exactly when its two inputs are equal.
// - Set/reset latch holds its state while set and reset are both low, except that the forced state settles to zero.
// - Set high with reset low stores one; reset high with set low stores zero.
// - Set and reset both high drive both latch outputs low; illegal use.
// - Clocked latch passes data while its data switch conducts, feedback off.
// - On clock sense change the clocked latch keeps the last data value.
// - Clocked latch may optionally have a reset forcing its stored value.
// - While clock low, flip-flop master loads data and slave holds output.
// - On rising edge master captures data, which passes through slave to output.
// - On falling edge slave latches, master reopens; output changes only on rises or on set/reset.
// - Flip-flop set and reset are each optional, independent of one another.
`timescale 1ns/1ps
`default_nettype none

module cgs_cells #(
  parameter bit CL_HAS_RESET = 1'b1,
  parameter bit FF_HAS_SET = 1'b1,
  parameter bit FF_HAS_RESET = 1'b1
) (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Cell inputs
  input wire cgs_pkg::cgs_in_s cells_in,
  // Cell outputs
  output var cgs_pkg::cgs_out_s cells_out
);

  // True and complement pair from one level
  function automatic logic [1:0] cgs_pair(input logic level);
    cgs_pair = {level, ~level};
  endfunction : cgs_pair

  // Complex gates: two paired inputs and one override, no stored state
  function automatic logic cgs_and_nor(input logic [1:0] pair, input logic ovr);
    cgs_and_nor = ~((&pair) | ovr);
  endfunction : cgs_and_nor

  function automatic logic cgs_or_nand(input logic [1:0] pair, input logic ovr);
    cgs_or_nand = ~ovr | ~(|pair);
  endfunction : cgs_or_nand

  // One when the two inputs differ; shared by both exclusive gates
  function automatic logic cgs_differ(input logic [1:0] pair);
    cgs_differ = pair[1] ^ pair[0];
  endfunction : cgs_differ

  // Next latch state; set has no precedence, both high is the forced state
  function automatic cgs_pkg::cgs_rs_e cgs_rs_next(input cgs_pkg::cgs_rs_e cur,
    input logic set, input logic reset);
    cgs_rs_next = cur;
    unique case ({set, reset})
      cgs_pkg::CGS_RS_IN_HOLD:
      begin
        // Leaving the forced state with both low is undefined; settle to zero
        if (cur == cgs_pkg::CGS_RS_FORCED)
        begin
          cgs_rs_next = cgs_pkg::CGS_RS_ZERO;
        end
      end
      cgs_pkg::CGS_RS_IN_SET:
      begin
        cgs_rs_next = cgs_pkg::CGS_RS_ONE;
      end
      cgs_pkg::CGS_RS_IN_RESET:
      begin
        cgs_rs_next = cgs_pkg::CGS_RS_ZERO;
      end
      // both high forces both outputs low
      cgs_pkg::CGS_RS_IN_BOTH:
      begin
        cgs_rs_next = cgs_pkg::CGS_RS_FORCED;
      end
    endcase
  endfunction : cgs_rs_next

  // Latch outputs for a state; only the unused code falls to the default
  function automatic logic [1:0] cgs_rs_outs(input cgs_pkg::cgs_rs_e state);
    unique case (state)
      cgs_pkg::CGS_RS_ZERO:
      begin
        cgs_rs_outs = cgs_pair(1'b0);
      end
      cgs_pkg::CGS_RS_ONE:
      begin
        cgs_rs_outs = cgs_pair(1'b1);
      end
      cgs_pkg::CGS_RS_FORCED:
      begin
        cgs_rs_outs = cgs_pkg::CGS_PAIR_LOW;
      end
      default:
      begin
        cgs_rs_outs = cgs_pair(1'b0);
      end
    endcase
  endfunction : cgs_rs_outs

  logic [1:0] rst_sync_r;
  logic rst_n;
  cgs_pkg::cgs_state_s st_r;
  cgs_pkg::cgs_state_s st_nxt;
  logic tim_rise;

  // Release reset through two flops; assert at once
  // Only the second flop is read, so all state leaves reset on one edge
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rst_sync_r <= cgs_pkg::CGS_SYNC_RST;
    end
    else
    begin
      rst_sync_r <= {rst_sync_r[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_r[1];

  // Rise of timing_input seen from two samples; it must be low at one clk edge first
  assign tim_rise = cells_in.timing_input && !st_r.tim_prev;

  always_comb
  begin
    st_nxt = st_r;
    st_nxt.outs.and_nor = cgs_and_nor(cells_in.ao_pair, cells_in.ao_ovr);
    st_nxt.outs.or_nand = cgs_or_nand(cells_in.on_pair, cells_in.on_ovr);
    st_nxt.outs.diff = cgs_differ(cells_in.x_in);
    st_nxt.outs.match = ~cgs_differ(cells_in.x_in);

    // Set/reset latch
    st_nxt.rs = cgs_rs_next(st_r.rs, cells_in.rs_set, cells_in.rs_reset);
    {st_nxt.outs.rs_q, st_nxt.outs.rs_qn} = cgs_rs_outs(st_nxt.rs);

    // Clocked latch: data switch conducts while timing_input high
    // Clear outranks data, so a power-on clear holds whatever timing_input does
    if (CL_HAS_RESET && cells_in.cl_reset)
    begin
      st_nxt.cl_store = 1'b0;
    end
    else if (cells_in.timing_input)
    begin
      st_nxt.cl_store = cells_in.cl_data;
    end
    else
    begin
      st_nxt.cl_store = st_r.cl_store;
    end
    {st_nxt.outs.cl_q, st_nxt.outs.cl_qn} = cgs_pair(st_nxt.cl_store);

    // Master-slave flip-flop
    st_nxt.tim_prev = cells_in.timing_input;
    if (!cells_in.timing_input)
    begin
      st_nxt.ff_master = cells_in.ff_data;
    end
    // capture on rise, pass to output
    if (tim_rise)
    begin
      {st_nxt.outs.ff_q, st_nxt.outs.ff_qn} = cgs_pair(st_r.ff_master);
    end
    // output otherwise held; slave closes on fall
    // Overrides force the master too, so a later rise cannot restore old data
    // each override present only if enabled
    // overrides beat the clock; both give both low
    if (FF_HAS_SET && FF_HAS_RESET && cells_in.ff_set && cells_in.ff_reset)
    begin
      {st_nxt.outs.ff_q, st_nxt.outs.ff_qn} = cgs_pkg::CGS_PAIR_LOW;
      st_nxt.ff_master = 1'b0;
    end
    else if (FF_HAS_RESET && cells_in.ff_reset)
    begin
      {st_nxt.outs.ff_q, st_nxt.outs.ff_qn} = cgs_pair(1'b0);
      st_nxt.ff_master = 1'b0;
    end
    else if (FF_HAS_SET && cells_in.ff_set)
    begin
      {st_nxt.outs.ff_q, st_nxt.outs.ff_qn} = cgs_pair(1'b1);
      st_nxt.ff_master = 1'b1;
    end
  end

  // power-on reset clears every storage cell
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_r <= cgs_pkg::CGS_STATE_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  assign cells_out = st_r.outs;

endmodule : cgs_cells

`default_nettype wire

// ==== tb/cgs_cells_props.sv ====
// Checker for the cell block outputs
`timescale 1ns/1ps
`default_nettype none
module cgs_cells_props (
  // Clock and reset
  input wire logic clk,
  input wire logic resetn,
  // Cells
  input wire cgs_pkg::cgs_in_s cells_in,
  input wire cgs_pkg::cgs_out_s cells_out
);
  logic [1:0] n_r;
  wire ok = n_r == 2'h3;
  cgs_pkg::cgs_in_s i;
  cgs_pkg::cgs_out_s o;
  assign i = cells_in;
  assign o = cells_out;
  // Outputs lag release by the synchroniser
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      n_r <= 2'h0;
    end
    else if (!ok)
    begin
      n_r <= n_r + 2'h1;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  a_and_nor_fn: assert property (
    ok |-> o.and_nor == !(&$past(i.ao_pair) || $past(i.ao_ovr))) else $error("and_nor bad");
  a_or_nand_fn: assert property (
    ok |-> o.or_nand == (!$past(i.on_ovr) || $past(i.on_pair) == 2'h0)) else $error("or_nand bad");
  a_exclusive_fn: assert property (
    ok |-> {o.diff, o.match} == {^$past(i.x_in), ~^$past(i.x_in)}) else $error("xor bad");
  a_rs_set_one: assert property (
    ok && $past(i.rs_set) && !$past(i.rs_reset) |-> o.rs_q && !o.rs_qn) else $error("rs set");
  a_rs_both_low: assert property (
    ok && $past(i.rs_set) && $past(i.rs_reset) |-> !o.rs_q && !o.rs_qn) else $error("rs both");
  a_cl_pass_data: assert property (
    ok && $past(i.timing_input) && !$past(i.cl_reset) |-> o.cl_q == $past(i.cl_data))
    else $error("latch pass");
  a_ff_override: assert property (
    ok && ($past(i.ff_set) || $past(i.ff_reset)) |-> o.ff_q == ($past(i.ff_set) &
    !$past(i.ff_reset)) && o.ff_qn == ($past(i.ff_reset) & !$past(i.ff_set)))
    else $error("ff override");
  a_ff_rise_load: assert property (
    ok && $past(ok) && $past(i.timing_input) && !$past(i.timing_input, 2) &&
    !$past(i.ff_set) && !$past(i.ff_reset) && !$past(i.ff_set, 2) && !$past(i.ff_reset, 2)
    |-> o.ff_q == $past(i.ff_data, 2)) else $error("ff capture");
  a_ff_hold_no_rise: assert property (
    ok && $past(ok) && !($past(i.timing_input) && !$past(i.timing_input, 2)) &&
    !$past(i.ff_set) && !$past(i.ff_reset) |-> $stable(o.ff_q) && $stable(o.ff_qn))
    else $error("ff hold");
endmodule : cgs_cells_props
bind cgs_cells cgs_cells_props cgs_cells_props_i (
  .clk(clk), .resetn(resetn), .cells_in(cells_in), .cells_out(cells_out));
`default_nettype wire

// ==== tb/test_cgs_cells.sv ====
// Self-checking bench for the cell block
`timescale 1ns/1ps
`default_nettype none
module test_cgs_cells;
  logic clk = 1'b0;
  logic resetn = 1'b0;
  cgs_pkg::cgs_in_s ci = '0;
  cgs_pkg::cgs_out_s co;
  int mismatches = 0;
  int samples_checked = 0;
  always #25 clk = ~clk;
  cgs_cells cgs_cells_i (
    .clk(clk),
    .resetn(resetn),
    .cells_in(ci),
    .cells_out(co)
  );
  task automatic cyc();
    @(posedge clk);
    #5;
  endtask : cyc
  task automatic chk(input logic [1:0] a, input logic [1:0] e);
    samples_checked++;
    if (a !== e)
    begin
      mismatches++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e);
    end
  endtask : chk
  task automatic end_sim();
    if (mismatches == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_sim
  task automatic t_gates();
    logic [2:0] v;
    for (int k = 0; k < 8; k++)
    begin
      v = 3'(k);
      {ci.ao_pair, ci.ao_ovr, ci.on_pair, ci.on_ovr} = {v, v};
      ci.x_in = v[1:0];
      cyc();
      chk({co.and_nor, co.or_nand}, {!(&v[2:1] || v[0]), !v[0] || !(|v[2:1])});
      chk({co.diff, co.match}, {^v[1:0], ~^v[1:0]});
    end
  endtask : t_gates
  task automatic t_rs();
    logic [3:0] tab [5] = '{4'ha, 4'h2, 4'h5, 4'hc, 4'h1};
    foreach (tab[k])
    begin
      {ci.rs_set, ci.rs_reset} = tab[k][3:2];
      cyc();
      chk({co.rs_q, co.rs_qn}, tab[k][1:0]);
    end
  endtask : t_rs
  task automatic t_cl();
    logic [3:0] tab [6] = '{4'hd, 4'h1, 4'h1, 4'h8, 4'he, 4'h4};
    foreach (tab[k])
    begin
      {ci.timing_input, ci.cl_data, ci.cl_reset} = tab[k][3:1];
      cyc();
      chk({co.cl_q, co.cl_qn}, {tab[k][0], !tab[k][0]});
    end
  endtask : t_cl
  task automatic t_ff();
    logic [5:0] tab [9] = '{6'h11, 6'h32, 6'h22, 6'h02, 6'h31, 6'h0a, 6'h05, 6'h2a, 6'h0c};
    foreach (tab[k])
    begin
      {ci.timing_input, ci.ff_data, ci.ff_set, ci.ff_reset} = tab[k][5:2];
      cyc();
      chk({co.ff_q, co.ff_qn}, tab[k][1:0]);
    end
  endtask : t_ff
  initial
  begin
    #20us;
    mismatches++;
    end_sim();
  end
  initial
  begin
    repeat (3) @(posedge clk);
    #5 resetn = 1'b1;
    repeat (2) cyc();
    chk({co.rs_q, co.rs_qn}, 2'h1);
    chk({co.cl_q, co.ff_q}, 2'h0);
    t_gates();
    t_rs();
    t_cl();
    t_ff();
    end_sim();
  end
endmodule : test_cgs_cells
`default_nettype wire
